// ### dpram_ctrl_pkg.sv
package dpram_ctrl_pkg;

  // Port count and geometry of one port
  localparam int NPORT  = 2;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 18;
  localparam int BE_W   = 2;

  // Mailbox locations, port 0 is left, port 1 is right
  localparam logic [ADDR_W-1:0] MBOX_ADDR_LEFT  = 19'h7fffe;
  localparam logic [ADDR_W-1:0] MBOX_ADDR_RIGHT = 19'h7ffff;

  // Register byte offsets
  localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_MASK   = 4'h4;
  localparam logic [3:0] REG_PORT_STATE = 4'h8;

  // Interrupt status layout
  localparam int IRQ_W          = 4;
  localparam int IRQ_MBOX_LSB   = 0;
  localparam int IRQ_WRAP_LSB   = 2;

  // Reset values
  localparam logic [IRQ_W-1:0]  IRQ_STATUS_RST = 4'h0;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST   = 4'h0;
  localparam logic [ADDR_W-1:0] CNT_RST        = 19'h00000;
  localparam logic [ADDR_W-1:0] CNT_MASK_RST   = 19'h7ffff;
  localparam logic [DATA_W-1:0] MBOX_DATA_RST  = 18'h00000;

  // Lock cycles counted after reset release; a port with its loop enabled is ready the cycle after the count completes
  localparam logic [4:0] DLL_LOCK_CYC = 5'h10;

  // Pins of one port, all active high unless named _n
  typedef struct packed {
    logic              sel;
    logic              read_write_n;
    logic [BE_W-1:0]   byte_lane_enable;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] wdata;
    logic              counter_or_mask_select;
    logic              counter_clear_n;
    logic              counter_load_strobe_n;
    logic              counter_advance_enable_n;
    logic              wrap_select;
    logic              low_speed_select;
  } port_in_s;

  localparam port_in_s PORT_IN_IDLE = '{
    sel: 1'b0, read_write_n: 1'b1, byte_lane_enable: 2'h0, address: 19'h00000,
    wdata: 18'h00000, counter_or_mask_select: 1'b1, counter_clear_n: 1'b1,
    counter_load_strobe_n: 1'b1, counter_advance_enable_n: 1'b1,
    wrap_select: 1'b0, low_speed_select: 1'b0};

endpackage

// ### dpram_port_ctrl.sv
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
// Contract
// R1 - A low read_write_n requests a write and a high one a read, and that access is performed.
// R2 - The two highest locations are mailboxes, one owned by each port, for messages between ports.
// R3 - A write by one port to the other port's mailbox drives the owner's mailbox_irq_n low.
// R4 - A read by a port of its own mailbox returns its mailbox_irq_n high.
// R5 - counter_wrap_irq_n goes low when an increment brings all unmasked counter bits to one.
// R6 - At maximum count with wrap_select low the next increment clears the unmasked bits.
// R7 - At maximum count with wrap_select high the next increment reloads from the mirror.
// R8 - Master reset acts without any clock and resets both ports at once.
// R9 - The system applies a master reset after power-up before using either port.
// R10 - An asserted low_speed_select disables that port's delay-locked loop.
// R11 - A port's ready output rises once the port can operate and stays low before.
// R12 - Master reset zeroes counters, sets masks to all ones and drives every interrupt high.
// R13 - The topmost address is the right mailbox and the next lower one the left mailbox.
// R14 - Mailbox set and clear happen only with at least one byte lane enabled.
// R15 - Reading the other mailbox never clears, writing the own mailbox never sets.
// R16 - Each port's controls and request are sampled on their own port's clock edge; the code samples both ports on the one mclk edge.
module dpram_port_ctrl
  import dpram_ctrl_pkg::*;
(
  // Clock and resets
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  input  wire logic                           clk_en,
  input  wire logic                           master_reset_n,
  // Port pins
  input  wire port_in_s                       port_in [NPORT],
  // Avalon-MM slave
  input  wire logic [3:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  output logic                                irq,
  // Port outputs
  output logic      [NPORT-1:0]               mailbox_irq_n,
  output logic      [NPORT-1:0]               counter_wrap_irq_n,
  output logic      [NPORT-1:0]               ready,
  output logic      [NPORT-1:0]               dll_enable,
  output logic      [NPORT-1:0][ADDR_W-1:0]   counter_addr,
  output logic      [NPORT-1:0][DATA_W-1:0]   mailbox_rdata
);

  port_in_s          pin_q1   [NPORT];
  port_in_s          pin_q2   [NPORT];
  logic [DATA_W-1:0] mbox_data_r [NPORT];
  logic [NPORT-1:0]  wr_own;
  logic [NPORT-1:0]  wr_opp;
  logic [NPORT-1:0]  rd_own;
  logic [NPORT-1:0]  rd_opp;
  logic [NPORT-1:0]  wrap_ev;
  logic [NPORT-1:0]  mbox_irq_n_r;
  logic [NPORT-1:0]  wrap_irq_n_r;
  logic [NPORT-1:0]  ready_r;
  logic [NPORT-1:0]  dll_en_r;
  logic [NPORT-1:0][ADDR_W-1:0] cnt_r;
  logic [NPORT-1:0][DATA_W-1:0] rdata_r;

  // Two-stage pin synchronisers
  always_ff @(posedge mclk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (!reset_n) begin
        pin_q1[p] <= PORT_IN_IDLE;
        pin_q2[p] <= PORT_IN_IDLE;
      end else if (clk_en) begin
        pin_q1[p] <= port_in[p]; // R16
        pin_q2[p] <= pin_q1[p];
      end
    end
  end

  // Master reset: asserts at once, releases on the clock
  logic [1:0] master_reset_n_sync_r;
  logic       port_rst_n;

  always_ff @(posedge mclk or negedge master_reset_n) begin
    if (!master_reset_n) begin // R8
      master_reset_n_sync_r <= 2'h0;
    end else if (clk_en) begin
      master_reset_n_sync_r <= {master_reset_n_sync_r[0], 1'b1};
    end
  end

  assign port_rst_n = master_reset_n_sync_r[1];

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    localparam int O = NPORT - 1 - g;
    localparam logic [ADDR_W-1:0] OWN_ADDR = (g == 1) ? MBOX_ADDR_RIGHT : MBOX_ADDR_LEFT; // R13
    localparam logic [ADDR_W-1:0] OPP_ADDR = (g == 1) ? MBOX_ADDR_LEFT : MBOX_ADDR_RIGHT;

    port_in_s          s;
    logic [ADDR_W-1:0] mask_r;
    logic [ADDR_W-1:0] mirror_r;
    logic [ADDR_W-1:0] acc_addr;
    logic [ADDR_W-1:0] cnt_inc;
    logic [ADDR_W-1:0] cnt_nxt;
    logic [ADDR_W-1:0] mask_nxt;
    logic [ADDR_W-1:0] mirror_nxt;
    logic [DATA_W-1:0] mbox_nxt;
    logic [DATA_W-1:0] be_bits;
    logic [4:0]        lock_cnt_r;
    logic              any_be;
    logic              hit_own;
    logic              hit_opp;
    logic              cnt_mode;
    logic              op_clear;
    logic              op_load;
    logic              op_inc;
    logic              at_max;
    logic              inc_hits_max;
    logic              mbox_set;
    logic              mbox_clr;
    logic              wrap_clr;
    logic              lock_done;
    logic [DATA_W-1:0] opp_bits;
    logic [ADDR_W-1:0] count_r;
    logic [DATA_W-1:0] mdata_r;
    logic [DATA_W-1:0] rdbuf_r;
    logic              flag_n_r;
    logic              wflag_n_r;
    logic              rdy_r;
    logic              dll_r;

    assign s        = pin_q2[g];
    assign acc_addr = s.counter_load_strobe_n ? cnt_r[g] : s.address;
    assign any_be   = |s.byte_lane_enable; // R14
    assign hit_own  = s.sel & any_be & (acc_addr == OWN_ADDR); // R2
    assign hit_opp  = s.sel & any_be & (acc_addr == OPP_ADDR);
    assign wr_own[g] = hit_own & ~s.read_write_n; // R1
    assign wr_opp[g] = hit_opp & ~s.read_write_n;
    assign rd_own[g] = hit_own & s.read_write_n;
    assign rd_opp[g] = hit_opp & s.read_write_n;

    // Mailbox flag: set by the other port only, cleared by own read only
    assign mbox_set = wr_opp[O]; // R3 R15
    assign mbox_clr = rd_own[g]; // R4 R15

    // Mailbox storage, written by either port
    assign be_bits  = {{(DATA_W/2){s.byte_lane_enable[1]}}, {(DATA_W/2){s.byte_lane_enable[0]}}};
    assign opp_bits = {{(DATA_W/2){pin_q2[O].byte_lane_enable[1]}},
                       {(DATA_W/2){pin_q2[O].byte_lane_enable[0]}}};
    assign mbox_nxt = wr_own[g] ? ((s.wdata & be_bits) | (mdata_r & ~be_bits)) : // R1
                      wr_opp[O] ? ((pin_q2[O].wdata & opp_bits) | (mdata_r & ~opp_bits)) :
                      mdata_r;

    // Counter control decode
    assign cnt_mode = s.counter_or_mask_select;
    assign op_clear = ~s.counter_clear_n;
    assign op_load  = s.counter_clear_n & ~s.counter_load_strobe_n & ~s.counter_advance_enable_n;
    assign op_inc   = cnt_mode & s.counter_clear_n & s.counter_load_strobe_n &
                      ~s.counter_advance_enable_n;
    assign at_max   = (cnt_r[g] & mask_r) == mask_r;
    assign cnt_inc  = (cnt_r[g] & ~mask_r) | (((cnt_r[g] | ~mask_r) + 19'h00001) & mask_r);
    assign inc_hits_max = op_inc & ~at_max & ((cnt_inc & mask_r) == mask_r); // R5
    assign wrap_ev[g]   = inc_hits_max;
    assign wrap_clr     = cnt_mode & (op_clear | op_load | (op_inc & ~inc_hits_max));

    assign cnt_nxt = (cnt_mode & op_clear)  ? (cnt_r[g] & ~mask_r) :
                     (cnt_mode & op_load)   ? s.address :
                     (op_inc & at_max)      ? (s.wrap_select ? mirror_r : // R7
                                               (cnt_r[g] & ~mask_r)) :    // R6
                     op_inc                 ? cnt_inc : cnt_r[g];
    assign mirror_nxt = (cnt_mode & (op_clear | op_load)) ? cnt_nxt : mirror_r;
    assign mask_nxt   = (~cnt_mode & op_clear) ? CNT_MASK_RST :
                        (~cnt_mode & op_load)  ? s.address : mask_r;

    assign lock_done = (lock_cnt_r == DLL_LOCK_CYC);

    // Counter, mirror and mask
    always_ff @(posedge mclk or negedge port_rst_n) begin
      if (!port_rst_n) begin // R8 R12
        count_r  <= CNT_RST;
        mirror_r <= CNT_RST;
        mask_r   <= CNT_MASK_RST;
      end else if (!reset_n) begin
        count_r  <= CNT_RST;
        mirror_r <= CNT_RST;
        mask_r   <= CNT_MASK_RST;
      end else if (clk_en) begin
        count_r  <= cnt_nxt;
        mirror_r <= mirror_nxt;
        mask_r   <= mask_nxt;
      end
    end

    // Interrupt flags, set wins over clear
    always_ff @(posedge mclk or negedge port_rst_n) begin
      if (!port_rst_n) begin // R12
        flag_n_r  <= 1'b1;
        wflag_n_r <= 1'b1;
      end else if (!reset_n) begin
        flag_n_r  <= 1'b1;
        wflag_n_r <= 1'b1;
      end else if (clk_en) begin
        flag_n_r  <= ~(mbox_set | (~flag_n_r & ~mbox_clr)); // R3 R4
        wflag_n_r <= ~(inc_hits_max | (~wflag_n_r & ~wrap_clr)); // R5
      end
    end

    // Mailbox contents and read capture
    always_ff @(posedge mclk or negedge port_rst_n) begin
      if (!port_rst_n) begin
        mdata_r <= MBOX_DATA_RST;
        rdbuf_r <= MBOX_DATA_RST;
      end else if (!reset_n) begin
        mdata_r <= MBOX_DATA_RST;
        rdbuf_r <= MBOX_DATA_RST;
      end else if (clk_en) begin
        mdata_r <= mbox_nxt;
        if (rd_own[g]) begin
          rdbuf_r <= mdata_r;
        end else if (rd_opp[g]) begin
          rdbuf_r <= mbox_data_r[O];
        end
      end
    end

    // Loop lock count and port ready
    always_ff @(posedge mclk or negedge port_rst_n) begin
      if (!port_rst_n) begin
        lock_cnt_r <= 5'h00;
        rdy_r      <= 1'b0;
        dll_r      <= 1'b0;
      end else if (!reset_n) begin
        lock_cnt_r <= 5'h00;
        rdy_r      <= 1'b0;
        dll_r      <= 1'b0;
      end else if (clk_en) begin
        dll_r <= ~s.low_speed_select; // R10
        if (!s.low_speed_select && !lock_done) begin
          lock_cnt_r <= lock_cnt_r + 5'h01;
        end
        rdy_r <= s.low_speed_select | lock_done; // R11
      end
    end

    // Per-port state onto the shared vectors
    assign cnt_r[g]        = count_r;
    assign mbox_irq_n_r[g] = flag_n_r;
    assign wrap_irq_n_r[g] = wflag_n_r;
    assign mbox_data_r[g]  = mdata_r;
    assign rdata_r[g]      = rdbuf_r;
    assign ready_r[g]      = rdy_r;
    assign dll_en_r[g]     = dll_r;
  end

  // Register bus
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_w1c;
  logic [IRQ_W-1:0] irq_status_nxt;
  logic [31:0]      rd_mux;
  logic             bus_take;
  logic             wr_status;
  logic             wr_mask;
  logic             irq_r;
  logic             waitreq_r;
  logic [31:0]      rdata_bus_r;

  assign irq_ev[IRQ_MBOX_LSB +: NPORT] = {wr_opp[0], wr_opp[1]}; // R3
  assign irq_ev[IRQ_WRAP_LSB +: NPORT] = wrap_ev;
  assign bus_take  = (avs_read | avs_write) & ~waitreq_r;
  assign wr_status = bus_take & avs_write & (avs_address == REG_IRQ_STATUS);
  assign wr_mask   = bus_take & avs_write & (avs_address == REG_IRQ_MASK);
  assign irq_w1c   = wr_status ? avs_writedata[IRQ_W-1:0] : 4'h0;
  assign irq_status_nxt = irq_ev | (irq_status_r & ~irq_w1c);
  assign rd_mux = (avs_address == REG_IRQ_STATUS) ? {28'h0000000, irq_status_r} :
                  (avs_address == REG_IRQ_MASK)   ? {28'h0000000, irq_mask_r} :
                  (avs_address == REG_PORT_STATE) ? {24'h000000, dll_en_r, ready_r,
                                                     wrap_irq_n_r, mbox_irq_n_r} :
                  32'h00000000;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_status_r <= IRQ_STATUS_RST;
      irq_mask_r   <= IRQ_MASK_RST;
      irq_r        <= 1'b0;
      waitreq_r    <= 1'b1;
      rdata_bus_r  <= 32'h00000000;
    end else if (clk_en) begin
      irq_status_r <= irq_status_nxt;
      if (wr_mask) begin
        irq_mask_r <= avs_writedata[IRQ_W-1:0];
      end
      irq_r     <= |(irq_status_r & irq_mask_r);
      waitreq_r <= ~((avs_read | avs_write) & waitreq_r);
      if ((avs_read | avs_write) & waitreq_r) begin
        rdata_bus_r <= rd_mux;
      end
    end
  end

  assign avs_readdata       = rdata_bus_r;
  assign avs_waitrequest    = waitreq_r;
  assign irq                = irq_r;
  assign mailbox_irq_n      = mbox_irq_n_r;
  assign counter_wrap_irq_n = wrap_irq_n_r;
  assign ready              = ready_r;
  assign dll_enable         = dll_en_r;
  assign counter_addr       = cnt_r;
  assign mailbox_rdata      = rdata_r;

endmodule

// ### dpram_port_ctrl_props.sv
`timescale 1ns/1ns
module dpram_port_ctrl_props
  import dpram_ctrl_pkg::*;
(
  // Clock and resets
  input wire logic             mclk,
  input wire logic             reset_n,
  input wire logic             master_reset_n,
  // Pins and outputs
  input wire port_in_s         port_in [NPORT],
  input wire logic [1:0]       mailbox_irq_n,
  input wire logic [1:0]       counter_wrap_irq_n,
  input wire logic [1:0]       ready,
  input wire logic [1:0]       dll_enable,
  input wire logic [1:0][18:0] counter_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire port_in_s l = port_in[0];
  wire port_in_s r = port_in[1];
  wire run = reset_n && master_reset_n;
  wire lw = l.sel && !l.read_write_n && !l.counter_load_strobe_n && l.address == MBOX_ADDR_RIGHT;
  wire lr = l.sel && l.read_write_n && !l.counter_load_strobe_n && l.address == MBOX_ADDR_RIGHT;
  wire rr = r.sel && r.read_write_n && !r.counter_load_strobe_n && r.address == MBOX_ADDR_RIGHT;
  wire inc = l.counter_or_mask_select && l.counter_clear_n && l.counter_load_strobe_n
             && !l.counter_advance_enable_n;
  property p_master_reset_n; !master_reset_n |-> mailbox_irq_n == 2'h3 && counter_wrap_irq_n == 2'h3
    && ready == 2'h0 && counter_addr == '0; endproperty
  a_master_reset_n: assert property (p_master_reset_n) else $error("master reset outputs wrong");
  property p_dll; run && $past(run) && $past(run, 2) && $past(run, 3) |-> dll_enable ==
    ~{$past(r.low_speed_select, 3), $past(l.low_speed_select, 3)}; endproperty
  a_dll: assert property (p_dll) else $error("loop enable wrong");
  property p_set; lw && l.byte_lane_enable != 2'h0 |-> ##3 !mailbox_irq_n[1]; endproperty
  a_set: assert property (p_set) else $error("mailbox flag not set");
  property p_clr; rr && r.byte_lane_enable != 2'h0 |-> ##3 mailbox_irq_n[1]; endproperty
  a_clr: assert property (p_clr) else $error("mailbox flag not cleared");
  property p_nobe; lw && l.byte_lane_enable == 2'h0 && mailbox_irq_n[1] |-> ##3 mailbox_irq_n[1];
  endproperty
  a_nobe: assert property (p_nobe) else $error("flag set without lanes");
  property p_other; lr && !mailbox_irq_n[1] |-> ##3 !mailbox_irq_n[1]; endproperty
  a_other: assert property (p_other) else $error("flag cleared by other port");
  property p_wrap; inc ##2 counter_addr[0] == 19'h7fffe |-> ##1 !counter_wrap_irq_n[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missing");
  property p_wclr; inc && !l.wrap_select ##2 counter_addr[0] == 19'h7ffff
    |-> ##1 counter_addr[0] == 19'h0; endproperty
  a_wclr: assert property (p_wclr) else $error("counter not cleared at wrap");
  c_set: cover property (lw ##3 !mailbox_irq_n[1]);
  c_wrap: cover property (inc ##3 !counter_wrap_irq_n[0]);
  c_master_reset_n: cover property (!master_reset_n ##1 master_reset_n);
endmodule

// ### dpram_host.sv
`timescale 1ns/1ns
module dpram_host
  import dpram_ctrl_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Port pins
  output port_in_s  pins [NPORT]
);
  port_in_s   cur [NPORT] = '{PORT_IN_IDLE, PORT_IN_IDLE};
  logic [1:0] slow = 2'h0;
  always_comb begin
    pins = cur;
    pins[0].low_speed_select = slow[0];
    pins[1].low_speed_select = slow[1];
  end
  // One cycle of pins after an edge, then idle
  task automatic drive(input int p, input port_in_s v);
    @(posedge mclk);
    cur[p] <= v;
    @(posedge mclk);
    cur[p] <= PORT_IN_IDLE;
  endtask
  // Mailbox access on the address pins
  task automatic access(input int p, input logic rw, input logic [1:0] be, input logic [18:0] a);
    port_in_s v;
    v = PORT_IN_IDLE;
    v.sel = 1'b1;
    v.read_write_n = rw;
    v.byte_lane_enable = be;
    v.address = a;
    v.wdata = a[17:0];
    v.counter_load_strobe_n = 1'b0;
    drive(p, v);
  endtask
  // Counter load or increment
  task automatic count(input int p, input logic ld, input logic wrap, input logic [18:0] a);
    port_in_s v;
    v = PORT_IN_IDLE;
    v.counter_load_strobe_n = ~ld;
    v.counter_advance_enable_n = 1'b0;
    v.wrap_select = wrap;
    v.address = a;
    drive(p, v);
  endtask
endmodule

// ### dpram_port_ctrl_tb.sv
`timescale 1ns/1ns
module dpram_port_ctrl_tb;
  import dpram_ctrl_pkg::*;
  logic             mclk = 1'b0;
  logic             reset_n = 1'b0;
  logic             master_reset_n = 1'b0;
  logic             clk_en = 1'b1;
  logic [3:0]       avs_address = 4'h0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0;
  logic [31:0]      avs_readdata, rd;
  logic             avs_waitrequest, irq;
  logic [1:0]       mailbox_irq_n, counter_wrap_irq_n, ready, dll_enable;
  logic [1:0][18:0] counter_addr;
  logic [1:0][17:0] mailbox_rdata;
  port_in_s         port_in [NPORT];
  int               bad_count = 0, checked = 0, cyc = 0;
  // Port, read_write_n, lanes, address, expected mailbox_irq_n
  logic [24:0]      rows [9] = '{
    {2'h0, 2'h3, 19'h7ffff, 2'h1}, {2'h1, 2'h3, 19'h7ffff, 2'h1}, {2'h0, 2'h3, 19'h7fffe, 2'h1},
    {2'h3, 2'h0, 19'h7ffff, 2'h1}, {2'h3, 2'h1, 19'h7ffff, 2'h3}, {2'h0, 2'h0, 19'h7ffff, 2'h3},
    {2'h2, 2'h2, 19'h7fffe, 2'h2}, {2'h1, 2'h3, 19'h7fffe, 2'h3}, {2'h2, 2'h3, 19'h7fffd, 2'h3}};
  always #5 mclk = ~mclk;
  dpram_host u_host (.mclk(mclk), .pins(port_in));
  dpram_port_ctrl dut (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .master_reset_n(master_reset_n),
    .port_in(port_in), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .irq(irq),
    .avs_waitrequest(avs_waitrequest), .mailbox_irq_n(mailbox_irq_n), .ready(ready),
    .counter_wrap_irq_n(counter_wrap_irq_n), .dll_enable(dll_enable),
    .counter_addr(counter_addr), .mailbox_rdata(mailbox_rdata));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checked %0d, bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (19) @(posedge mclk);
    #1 check({ready, dll_enable, mailbox_irq_n, counter_wrap_irq_n}, 8'h0f);
    @(posedge mclk);
    reset_n <= 1'b1;
    master_reset_n <= 1'b1;
    settle(1);
    check(ready, 2'h0);
    settle(25);
    check({ready, dll_enable}, 4'hf);
    @(posedge mclk);
    u_host.slow <= 2'h2;
    settle(4);
    check(dll_enable, 2'h1);
    @(posedge mclk);
    u_host.slow <= 2'h0;
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      u_host.access(rows[i][24], rows[i][23], rows[i][22:21], rows[i][20:2]);
      settle(4);
      check(mailbox_irq_n, rows[i][1:0]);
    end
    check(mailbox_rdata, {18'h3ffff, 18'h3fffe});
    $display("test mailbox done");
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    check(rd, 32'h3);
    bus(1'b0, REG_PORT_STATE, 32'h0);
    check(rd, 32'hff);
    bus(1'b1, REG_IRQ_MASK, 32'h2);
    settle(2);
    check(irq, 1'b1);
    bus(1'b1, REG_IRQ_STATUS, 32'h2);
    settle(2);
    check(irq, 1'b0);
    bus(1'b0, REG_IRQ_MASK, 32'h0);
    check(rd, 32'h2);
    bus(1'b1, 4'hc, 32'h5);
    bus(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    check(rd, 32'h1);
    $display("test registers done");
    u_host.count(1, 1'b1, 1'b0, 19'h00005);
    u_host.count(0, 1'b1, 1'b0, 19'h7fffd);
    u_host.count(0, 1'b0, 1'b0, 19'h0);
    u_host.count(0, 1'b0, 1'b0, 19'h0);
    settle(4);
    check({counter_wrap_irq_n, counter_addr[0]}, {2'h2, 19'h7ffff});
    u_host.count(0, 1'b0, 1'b0, 19'h0);
    settle(4);
    check(counter_addr[0], 19'h0);
    u_host.count(0, 1'b1, 1'b0, 19'h7fffe);
    u_host.count(0, 1'b0, 1'b1, 19'h0);
    u_host.count(0, 1'b0, 1'b1, 19'h0);
    settle(4);
    check(counter_addr, {19'h00005, 19'h7fffe});
    $display("test counter done");
    @(posedge mclk);
    clk_en <= 1'b0;
    u_host.count(1, 1'b0, 1'b0, 19'h0);
    settle(4);
    check(counter_addr[1], 19'h00005);
    @(posedge mclk);
    clk_en <= 1'b1;
    settle(4);
    check({ready, counter_addr[1]}, {2'h3, 19'h00005});
    $display("test clock enable done");
    @(posedge mclk);
    master_reset_n <= 1'b0;
    #1 check({ready, mailbox_irq_n, counter_wrap_irq_n, counter_addr}, {6'h0f, 38'h0});
    @(posedge mclk);
    master_reset_n <= 1'b1;
    settle(25);
    check(ready, 2'h3);
    $display("test master reset done");
    give_verdict();
  end
endmodule
bind dpram_port_ctrl dpram_port_ctrl_props u_props (
  .mclk(mclk), .reset_n(reset_n), .master_reset_n(master_reset_n), .port_in(port_in),
  .mailbox_irq_n(mailbox_irq_n), .counter_wrap_irq_n(counter_wrap_irq_n), .ready(ready),
  .dll_enable(dll_enable), .counter_addr(counter_addr));
